// ---- rtl/sdr_core.sv ----
// SDRAM device core: command capture, bank rows, mode settings, bursts and read latency.
// Assumes the command bus is driven by a controller on the same clock.
//
// Notes on behaviour
// RL1: All inputs sampled on clock rising edge.
// RL2: Four banks, 4096 rows, 256 columns, 16 bits.
// RL3: Reads and writes need an opened row first.
// RL4: Row open takes bank bits and row address.
// RL5: Read/write takes low eight lines as column.
// RL6: Controller starts with clock stable, masks high.
// RL7: Controller waits 100us issuing only idle commands.
// RL8: Controller then precharges every bank.
// RL9: Controller then gives two auto refreshes.
// RL10: Mode settings undefined until loaded.
// RL11: Controller idles one cycle after mode load; the controller model idles two.
// RL12: Mode settings change only on mode load.
// RL13: Mode layout: length, order, latency, mode, write.
// RL14: Controller loads modes only with banks idle.
// RL15: Lengths 1,2,4,8; full page sequential only.
// RL16: Full page runs until burst terminate.
// RL17: Burst wraps inside aligned length-sized block.
// RL18: Full page wraps to column zero.
// RL19: Order bit picks sequential or interleaved.
// RL20: Sequential adds index; interleaved XORs index.
// RL21: Read latency two or three clocks.
// RL22: Drive from edge n+m-1, valid by n+m.
// RL23: Controller avoids reserved mode encodings.
// RL24: Operating mode zero means normal operation.
// RL25: Write burst bit set makes writes single.
// RL26: Length codes 0-3,7; latency codes 2,3.
`timescale 1ns/10ps
`include "sdr_defs.svh"
module sdr_core #(
    parameter int BANKS = `SDR_BANKS,
    parameter int ROWS = `SDR_ROWS,
    parameter int COLS = `SDR_COLS,
    parameter int DQ_W = `SDR_DQ_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Command
    input wire logic clk_en,
    input wire logic chip_sel_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_en_n,
    // Address
    input wire logic bank_select_bit0,
    input wire logic bank_select_bit1,
    input wire logic [11:0] address_lines,
    // Data
    input wire logic [DQ_W/8-1:0] byte_mask,
    input wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0] dq_out,
    output logic [DQ_W/8-1:0] dq_oe
);
    import sdr_pkg::*;

    localparam int BANK_W = $clog2(BANKS);
    localparam int ROW_W = $clog2(ROWS);
    localparam int COL_W = $clog2(COLS);
    localparam int AW = BANK_W + ROW_W + COL_W;
    localparam int LANES = DQ_W / 8;

    logic rst_s1_r;
    logic rst_n;
    sdr_cmd_t cmd;
    logic [BANK_W-1:0] bank;
    logic [BANKS-1:0] open_r;
    logic [ROW_W-1:0] row_r [BANKS];
    logic [`SDR_MODE_W-1:0] mode_r;
    sdr_blen_t blen;
    logic lat3;
    logic write_single;
    logic rw_ok;
    logic start_burst;
    sdr_burst_kind_t kind_r;
    logic [BANK_W-1:0] burst_bank_r;
    logic [ROW_W-1:0] burst_row_r;
    logic rd_now;
    logic wr_cmd_now;
    logic wr_burst_now;
    logic [AW-1:0] wr_addr;
    logic [AW-1:0] rd_addr;
    logic [DQ_W-1:0] rd_data;
    logic [DQ_W-1:0] s1_data_r;
    logic s1_vld_r;
    logic [LANES-1:0] dqm_d1_r;
    logic out_vld;
    logic [DQ_W-1:0] out_data;

    sdr_burst_if #(.COL_W(COL_W)) bi ();

    // ==========================================
    // Reset release
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // ==========================================
    // Command decode
    // Deselect or a low clock enable both read as no operation
    always_comb
    begin
        if (chip_sel_n || !clk_en)
        begin
            cmd = SDR_CMD_NOP;
        end
        else
        begin
            cmd = sdr_cmd_t'({row_strobe_n, col_strobe_n, write_en_n}); // RL1
        end
    end

    assign bank = BANK_W'({bank_select_bit1, bank_select_bit0});

    // ==========================================
    // Bank rows
    for (genvar g = 0; g < BANKS; g++)
    begin : g_bank
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                open_r[g] <= 1'b0;
                row_r[g] <= '0;
            end
            else if (cmd == SDR_CMD_ACT && bank == BANK_W'(g) && !open_r[g])
            begin
                open_r[g] <= 1'b1; // RL4
                row_r[g] <= address_lines[ROW_W-1:0]; // RL4 RL2
            end
            else if (cmd == SDR_CMD_PRE && (address_lines[`SDR_AP_BIT] || bank == BANK_W'(g)))
            begin
                open_r[g] <= 1'b0;
            end
        end
    end

    // ==========================================
    // Operating mode settings
    // Reset value only gives simulation a defined start; real contents are unknown
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_r <= `SDR_MODE_RST; // RL10
        end
        else if (cmd == SDR_CMD_LMR)
        begin
            mode_r <= address_lines[`SDR_MODE_W-1:0]; // RL12 RL13 RL24
        end
    end

    // Reserved length codes fall back to single transfers
    always_comb
    begin
        case (mode_r[`SDR_MR_BL_MSB:`SDR_MR_BL_LSB])
            `SDR_BL_1: blen = SDR_LEN_1; // RL26
            `SDR_BL_2: blen = SDR_LEN_2; // RL26
            `SDR_BL_4: blen = SDR_LEN_4; // RL26
            `SDR_BL_8: blen = SDR_LEN_8; // RL26 RL15
            `SDR_BL_FULL: blen = SDR_LEN_FULL; // RL26 RL15
            default: blen = SDR_LEN_1;
        endcase
    end

    // Any latency code other than three behaves as two
    assign lat3 = mode_r[`SDR_MR_CL_MSB:`SDR_MR_CL_LSB] == `SDR_CL_3; // RL26 RL21
    assign write_single = mode_r[`SDR_MR_WB_BIT]; // RL25

    // ==========================================
    // Burst launch
    // A column command to a closed bank is dropped
    assign rw_ok = (cmd == SDR_CMD_RD || cmd == SDR_CMD_WR) && open_r[bank]; // RL3
    assign start_burst = rw_ok && !(cmd == SDR_CMD_WR && (write_single || blen == SDR_LEN_1)); // RL25

    assign bi.start = start_burst;
    // Any accepted column command truncates the running burst
    assign bi.stop = rw_ok || cmd == SDR_CMD_BST
        || (cmd == SDR_CMD_PRE && (address_lines[`SDR_AP_BIT] || bank == burst_bank_r)); // RL16
    // First write word is stored by the command itself
    assign bi.first_idx = cmd == SDR_CMD_WR;
    assign bi.start_col = address_lines[COL_W-1:0]; // RL5
    assign bi.len = blen;
    assign bi.interleave = mode_r[`SDR_MR_BT_BIT]; // RL19

    sdr_burst_gen #(.COL_W(COL_W)) u_burst (
        .clk(clk),
        .rst_n(rst_n),
        .bi(bi)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            kind_r <= SDR_BK_IDLE;
            burst_bank_r <= '0;
            burst_row_r <= '0;
        end
        else if (rw_ok)
        begin
            kind_r <= (cmd == SDR_CMD_RD) ? SDR_BK_READ : SDR_BK_WRITE;
            burst_bank_r <= bank;
            burst_row_r <= row_r[bank];
        end
        else if (!bi.active)
        begin
            kind_r <= SDR_BK_IDLE;
        end
    end

    // ==========================================
    // Storage access
    assign rd_now = bi.active && kind_r == SDR_BK_READ;
    assign wr_cmd_now = rw_ok && cmd == SDR_CMD_WR;
    assign wr_burst_now = bi.active && kind_r == SDR_BK_WRITE && !rw_ok;
    assign wr_addr = wr_cmd_now ? {bank, row_r[bank], address_lines[COL_W-1:0]}
        : {burst_bank_r, burst_row_r, bi.col};
    assign rd_addr = {burst_bank_r, burst_row_r, bi.col};

    // Write mask has no latency: the mask beside the data decides
    sdr_array #(.AW(AW), .DW(DQ_W)) u_array (
        .clk(clk),
        .wr_en(wr_cmd_now || wr_burst_now),
        .wr_addr(wr_addr),
        .wr_be(~byte_mask),
        .wr_data(dq_in),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // ==========================================
    // Read latency pipeline
    // A write command kills read words still in flight, freeing the data pins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_data_r <= '0;
            s1_vld_r <= 1'b0;
        end
        else
        begin
            s1_data_r <= rd_data;
            s1_vld_r <= rd_now && !wr_cmd_now; // RL21
        end
    end

    assign out_vld = lat3 ? s1_vld_r : rd_now; // RL21
    assign out_data = lat3 ? s1_data_r : rd_data;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dqm_d1_r <= '0;
        end
        else
        begin
            dqm_d1_r <= byte_mask;
        end
    end

    // Output flop loads at edge n+m-1; the word is then valid by edge n+m
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dq_out <= '0;
            dq_oe <= '0;
        end
        else
        begin
            dq_out <= out_data; // RL22
            dq_oe <= (out_vld && !wr_cmd_now) ? ~dqm_d1_r : '0; // RL22
        end
    end
endmodule

// ---- rtl/sdr_defs.svh ----
// Offsets, field positions, reset values and encodings of the SDRAM core.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SDR_DEFS_SVH
`define SDR_DEFS_SVH

// ==========================================
// Organisation
`define SDR_BANKS 4
`define SDR_ROWS 4096
`define SDR_COLS 256
`define SDR_DQ_W 16

// ==========================================
// Operating mode settings layout
`define SDR_MODE_W 12
`define SDR_MR_BL_LSB 0
`define SDR_MR_BL_MSB 2
`define SDR_MR_BT_BIT 3
`define SDR_MR_CL_LSB 4
`define SDR_MR_CL_MSB 6
`define SDR_MR_OPM_LSB 7
`define SDR_MR_OPM_MSB 8
`define SDR_MR_WB_BIT 9
`define SDR_MODE_RST 12'h000

// ==========================================
// Field encodings
`define SDR_BL_1 3'h0
`define SDR_BL_2 3'h1
`define SDR_BL_4 3'h2
`define SDR_BL_8 3'h3
`define SDR_BL_FULL 3'h7
`define SDR_CL_2 3'h2
`define SDR_CL_3 3'h3
`define SDR_OPM_NORMAL 2'h0

// ==========================================
// Address line roles
`define SDR_AP_BIT 10

`endif

// ---- rtl/sdr_pkg.sv ----
// Types shared by the SDRAM core modules.
// Assumes nothing beyond a SystemVerilog compiler.
package sdr_pkg;

    // Command code equals {row strobe, column strobe, write enable}
    typedef enum logic [2:0] {
        SDR_CMD_LMR = 3'b000,
        SDR_CMD_REF = 3'b001,
        SDR_CMD_PRE = 3'b010,
        SDR_CMD_ACT = 3'b011,
        SDR_CMD_WR = 3'b100,
        SDR_CMD_RD = 3'b101,
        SDR_CMD_BST = 3'b110,
        SDR_CMD_NOP = 3'b111
    } sdr_cmd_t;

    typedef enum logic [1:0] {
        SDR_BK_IDLE = 2'b00,
        SDR_BK_READ = 2'b01,
        SDR_BK_WRITE = 2'b10
    } sdr_burst_kind_t;

    typedef enum logic [2:0] {
        SDR_LEN_1 = 3'b000,
        SDR_LEN_2 = 3'b001,
        SDR_LEN_4 = 3'b010,
        SDR_LEN_8 = 3'b011,
        SDR_LEN_FULL = 3'b111
    } sdr_blen_t;

endpackage

// ---- rtl/sdr_burst_if.sv ----
// Carrier between the core and its burst column sequencer.
// Assumes sdr_pkg is compiled first.
`timescale 1ns/10ps
interface sdr_burst_if #(parameter int COL_W = 8);
    logic start;
    logic stop;
    logic first_idx;
    logic [COL_W-1:0] start_col;
    sdr_pkg::sdr_blen_t len;
    logic interleave;
    logic [COL_W-1:0] col;
    logic active;

    modport gen (input start, input stop, input first_idx, input start_col, input len, input interleave,
        output col, output active);
    modport user (output start, output stop, output first_idx, output start_col, output len, output interleave,
        input col, input active);
endinterface

// ---- rtl/sdr_burst_gen.sv ----
// Column sequencer: walks the columns of one burst, one per clock.
// Assumes start and stop come from logic on the same clock.
`timescale 1ns/10ps
module sdr_burst_gen #(
    parameter int COL_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    sdr_burst_if.gen bi
);
    import sdr_pkg::*;

    logic [COL_W-1:0] base_r;
    logic [COL_W-1:0] idx_r;
    logic active_r;
    sdr_blen_t len_r;
    logic ilv_r;
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] inblk;
    logic last;

    // ==========================================
    // Column within the aligned block
    always_comb
    begin
        case (len_r)
            SDR_LEN_1: mask = COL_W'(0);
            SDR_LEN_2: mask = COL_W'(1); // RL17
            SDR_LEN_4: mask = COL_W'(3); // RL17
            SDR_LEN_8: mask = COL_W'(7); // RL17
            SDR_LEN_FULL: mask = {COL_W{1'b1}}; // RL18
            default: mask = COL_W'(0);
        endcase
    end

    // Interleave is meaningless for full page, so it falls back to sequential
    assign inblk = (ilv_r && len_r != SDR_LEN_FULL) ? ((base_r ^ idx_r) & mask)
        : ((base_r + idx_r) & mask); // RL20 RL19 RL15
    assign bi.col = (base_r & ~mask) | inblk; // RL17
    // Full page never ends on its own
    assign last = (idx_r == mask) && (len_r != SDR_LEN_FULL); // RL16
    assign bi.active = active_r;

    // ==========================================
    // Sequencing
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_r <= '0;
            idx_r <= '0;
            active_r <= 1'b0;
            len_r <= SDR_LEN_1;
            ilv_r <= 1'b0;
        end
        else if (bi.start)
        begin
            base_r <= bi.start_col;
            idx_r <= bi.first_idx ? COL_W'(1) : COL_W'(0);
            active_r <= 1'b1;
            len_r <= bi.len;
            ilv_r <= bi.interleave;
        end
        else if (active_r)
        begin
            if (bi.stop || last)
            begin
                active_r <= 1'b0;
            end
            else
            begin
                idx_r <= idx_r + COL_W'(1); // RL18
            end
        end
    end
endmodule

// ---- rtl/sdr_array.sv ----
// Storage of the SDRAM core: one write port with byte enables, one read port.
// Assumes write and read addresses come from logic on the same clock.
`timescale 1ns/10ps
module sdr_array #(
    parameter int AW = 22,
    parameter int DW = 16
) (
    input wire logic clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW/8-1:0] wr_be,
    input wire logic [DW-1:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // ==========================================
    // Byte-lane writes
    always_ff @(posedge clk)
    begin
        for (int lane = 0; lane < DW / 8; lane++)
        begin
            if (wr_en && wr_be[lane])
            begin
                mem[wr_addr][lane*8 +: 8] <= wr_data[lane*8 +: 8];
            end
        end
    end

    // Unregistered read, so the core sees a word in the same cycle
    assign rd_data = mem[rd_addr];
endmodule

// ---- tb/sdr_core_properties.sv ----
// Checker of the SDRAM core read-data pins against command traffic.
// Assumes mode loads only with all bursts finished.
`timescale 1ns/10ps
`include "sdr_defs.svh"
module sdr_core_properties #(
    parameter int DQ_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Command and address
    input wire logic clk_en,
    input wire logic chip_sel_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_en_n,
    input wire logic bank_select_bit0,
    input wire logic bank_select_bit1,
    input wire logic [11:0] address_lines,
    // Data
    input wire logic [DQ_W/8-1:0] byte_mask,
    input wire logic [DQ_W-1:0] dq_in,
    input wire logic [DQ_W-1:0] dq_out,
    input wire logic [DQ_W/8-1:0] dq_oe
);
    import sdr_pkg::*;
    logic [2:0] cmd;
    logic [1:0] bank;
    logic acc, rd, wr, bst, quiet, cl3;
    logic [11:0] mode_r;
    logic [3:0] open_r;
    assign cmd = {row_strobe_n, col_strobe_n, write_en_n};
    assign bank = {bank_select_bit1, bank_select_bit0};
    assign acc = !chip_sel_n && clk_en;
    // Closed banks refuse reads and writes, so only open ones count
    assign rd = acc && cmd == SDR_CMD_RD && open_r[bank];
    assign wr = acc && cmd == SDR_CMD_WR && open_r[bank];
    assign bst = acc && cmd == SDR_CMD_BST;
    assign quiet = !(acc && cmd inside {SDR_CMD_RD, SDR_CMD_WR, SDR_CMD_BST, SDR_CMD_PRE, SDR_CMD_LMR});
    assign cl3 = mode_r[6:4] == `SDR_CL_3;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            mode_r <= `SDR_MODE_RST;
        else if (acc && cmd == SDR_CMD_LMR)
            mode_r <= address_lines;
    end
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            open_r <= 4'h0;
        else if (acc && cmd == SDR_CMD_ACT)
            open_r[bank] <= 1'b1;
        else if (acc && cmd == SDR_CMD_PRE)
            open_r <= address_lines[10] ? 4'h0 : open_r & ~(4'h1 << bank);
    end
    // ==========
    // Properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_rd4;
        rd && !cl3 && mode_r[2:0] == `SDR_BL_4 && byte_mask == 2'h0;
    endsequence
    sequence s_rd3;
        rd && cl3 ##1 !wr && byte_mask == 2'h0 ##1 !wr;
    endsequence
    chk_idle_after_reset: assert property ($rose(rstn) |-> (dq_oe == 2'h0)[*3])
        else $error("data pins driven right after reset");
    chk_oe_from_read: assert property ($rose(dq_oe[0]) |-> (cl3 ? $past(rd, 3) : $past(rd, 2)))
        else $error("data drive not at read latency");
    chk_burst_four: assert property (s_rd4 ##1 quiet[*5] |-> ##1 dq_oe == 2'h0 && $past(dq_oe, 4) == 2'h3)
        else $error("burst of four has wrong word count");
    chk_first_word_cl3: assert property (s_rd3 |-> ##1 dq_oe == 2'h3)
        else $error("first word late with latency three");
    chk_write_drops_oe: assert property (wr |=> dq_oe == 2'h0)
        else $error("data pins driven after write");
    chk_stop_cl2: assert property (bst && !cl3 |-> ##2 dq_oe == 2'h0)
        else $error("burst stop late with latency two");
    chk_stop_cl3: assert property (bst && cl3 |-> ##3 dq_oe == 2'h0)
        else $error("burst stop late with latency three");
    chk_lanes_match: assert property ($past(byte_mask[0] == byte_mask[1], 2) |-> dq_oe[0] == dq_oe[1])
        else $error("lane drives differ without mask");
endmodule

bind sdr_core sdr_core_properties #(.DQ_W(DQ_W)) u_props (.clk(clk), .rstn(rstn), .clk_en(clk_en),
    .chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_en_n(write_en_n),
    .bank_select_bit0(bank_select_bit0), .bank_select_bit1(bank_select_bit1), .address_lines(address_lines),
    .byte_mask(byte_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));

// ---- tb/sdr_ctl_model.sv ----
// Controller model driving command, address and data pins of the core.
// Assumes its tasks are called at a falling clock edge.
`timescale 1ns/10ps
module sdr_ctl_model (
    // Clock
    input wire logic clk,
    // Command and address
    output logic clk_en,
    output logic chip_sel_n,
    output logic row_strobe_n,
    output logic col_strobe_n,
    output logic write_en_n,
    output logic bank_select_bit0,
    output logic bank_select_bit1,
    output logic [11:0] address_lines,
    // Data
    output logic [1:0] byte_mask,
    output logic [15:0] dq_in
);
    import sdr_pkg::*;
    initial
    begin
        clk_en = 1'b1;
        byte_mask = 2'h3;
        chip_sel_n = 1'b1;
        {row_strobe_n, col_strobe_n, write_en_n} = SDR_CMD_NOP;
        {bank_select_bit1, bank_select_bit0} = 2'h0;
        address_lines = 12'h000;
        dq_in = 16'h0000;
    end
    // ==========
    // Commands
    task automatic issue(input sdr_cmd_t c, input logic [1:0] b, input logic [11:0] a, input logic [15:0] d);
        chip_sel_n = 1'b0;
        {row_strobe_n, col_strobe_n, write_en_n} = c;
        {bank_select_bit1, bank_select_bit0} = b;
        address_lines = a;
        // Undriven data keeps toggling, so a stale word never looks valid
        dq_in = (c == SDR_CMD_WR) ? d : ~dq_in;
        @(negedge clk);
    endtask
    task automatic put(input logic [15:0] d);
        {row_strobe_n, col_strobe_n, write_en_n} = SDR_CMD_NOP;
        dq_in = d;
        @(negedge clk);
    endtask
    // Command the core must ignore: deselected, or with clock enable low
    task automatic blocked(input sdr_cmd_t c, input logic [1:0] b, input logic [11:0] a, input logic by_select);
        chip_sel_n = by_select;
        clk_en = by_select;
        {row_strobe_n, col_strobe_n, write_en_n} = c;
        {bank_select_bit1, bank_select_bit0} = b;
        address_lines = a;
        dq_in = ~dq_in;
        @(negedge clk);
        clk_en = 1'b1;
    endtask
    task automatic set_mask(input logic [1:0] m);
        byte_mask = m;
    endtask
    task automatic nop(input int n);
        repeat (n) issue(SDR_CMD_NOP, 2'h0, 12'h000, 16'h0000);
    endtask
    task automatic load(input logic [11:0] mode);
        issue(SDR_CMD_PRE, 2'h0, 12'h400, 16'h0000);
        issue(SDR_CMD_LMR, 2'h0, mode, 16'h0000);
        nop(2);
    endtask
    task automatic init(input logic [11:0] mode);
        repeat (2000) @(negedge clk);
        nop(1);
        issue(SDR_CMD_PRE, 2'h0, 12'h400, 16'h0000);
        repeat (2) issue(SDR_CMD_REF, 2'h0, 12'h000, 16'h0000);
        byte_mask = 2'h0;
        load(mode);
    endtask
endmodule

// ---- tb/test_sdram_init_mode_burst_addressing.sv ----
// Bench of the SDRAM core: init, burst orders, latencies, single writes, full page.
// Assumes the checker binds itself to the core.
`timescale 1ns/10ps
`include "sdr_defs.svh"
module test_sdram_init_mode_burst_addressing;
    import sdr_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en, chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, bank_select_bit0, bank_select_bit1;
    logic [11:0] address_lines;
    logic [1:0] byte_mask, dq_oe;
    logic [15:0] dq_in, dq_out;
    logic [15:0] mem [256];
    int err_total = 0;
    int n_compared = 0;
    // ==========
    // Clock, model and core
    always #25 clk = ~clk;
    sdr_ctl_model ctl (.clk(clk), .clk_en(clk_en), .chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n),
        .col_strobe_n(col_strobe_n), .write_en_n(write_en_n), .bank_select_bit0(bank_select_bit0),
        .bank_select_bit1(bank_select_bit1), .address_lines(address_lines), .byte_mask(byte_mask), .dq_in(dq_in));
    sdr_core DUT (.clk(clk), .rstn(rstn), .clk_en(clk_en), .chip_sel_n(chip_sel_n), .row_strobe_n(row_strobe_n),
        .col_strobe_n(col_strobe_n), .write_en_n(write_en_n), .bank_select_bit0(bank_select_bit0),
        .bank_select_bit1(bank_select_bit1), .address_lines(address_lines), .byte_mask(byte_mask), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe));
    // ==========
    // Shared tasks
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic burst_wr(input logic [7:0] start, input int len, input logic [15:0] d0);
        for (int i = 0; i < len; i++)
        begin
            if (i == 0)
                ctl.issue(SDR_CMD_WR, 2'h2, {4'h0, start}, d0);
            else
                ctl.put(d0 + 16'(i));
        end
    endtask
    // ==========
    // Scenarios
    task automatic rd_check(input logic [11:0] mode, input logic [7:0] start);
        int len;
        logic [7:0] col;
        len = 1 << mode[1:0];
        ctl.load(mode);
        ctl.issue(SDR_CMD_ACT, 2'h2, 12'hABC, 16'h0000);
        ctl.issue(SDR_CMD_RD, 2'h2, {4'h0, start}, 16'h0000);
        ctl.nop(mode[6:4] == `SDR_CL_3 ? 2 : 1);
        for (int i = 0; i < len; i++)
        begin
            col = mode[3] ? start ^ 8'(i) : start + 8'(i);
            col = (start & ~8'(len - 1)) | (col & 8'(len - 1));
            check("read word", mem[col], dq_out);
            check("read drive", 16'h0003, 16'(dq_oe));
            ctl.nop(1);
        end
        check("burst end", 16'h0000, 16'(dq_oe));
    endtask
    task automatic single_write;
        ctl.load(12'h222);
        ctl.issue(SDR_CMD_ACT, 2'h2, 12'hABC, 16'h0000);
        burst_wr(8'h12, 4, 16'h1234);
        mem[8'h12] = 16'h1234;
        rd_check(12'h022, 8'h12);
    endtask
    task automatic full_page;
        ctl.load(12'h027);
        ctl.issue(SDR_CMD_ACT, 2'h2, 12'hABC, 16'h0000);
        burst_wr(8'hFE, 4, 16'h7000);
        ctl.issue(SDR_CMD_BST, 2'h2, 12'h000, 16'h0000);
        for (int i = 0; i < 4; i++)
            mem[8'hFE + 8'(i)] = 16'h7000 + 16'(i);
        ctl.load(12'h037);
        ctl.issue(SDR_CMD_ACT, 2'h2, 12'hABC, 16'h0000);
        ctl.issue(SDR_CMD_RD, 2'h2, 12'h0FE, 16'h0000);
        ctl.nop(2);
        for (int i = 0; i < 4; i++)
        begin
            check("page word", mem[8'hFE + 8'(i)], dq_out);
            if (i == 1)
                ctl.issue(SDR_CMD_BST, 2'h2, 12'h000, 16'h0000);
            else
                ctl.nop(1);
        end
        check("page end", 16'h0000, 16'(dq_oe));
    endtask
    task automatic refused;
        ctl.issue(SDR_CMD_PRE, 2'h2, 12'h000, 16'h0000);
        ctl.issue(SDR_CMD_RD, 2'h2, 12'h012, 16'h0000);
        ctl.nop(4);
        check("closed bank drive", 16'h0000, 16'(dq_oe));
    endtask
    task automatic other_bank;
        ctl.load(12'h020);
        ctl.issue(SDR_CMD_ACT, 2'h3, 12'h123, 16'h0000);
        ctl.issue(SDR_CMD_WR, 2'h3, 12'h012, 16'h5A5A);
        ctl.issue(SDR_CMD_ACT, 2'h2, 12'hABC, 16'h0000);
        ctl.blocked(SDR_CMD_RD, 2'h2, 12'h012, 1'b0);
        ctl.nop(1);
        check("clock enable drive", 16'h0000, 16'(dq_oe));
        ctl.blocked(SDR_CMD_RD, 2'h2, 12'h012, 1'b1);
        ctl.nop(1);
        check("deselect drive", 16'h0000, 16'(dq_oe));
        ctl.set_mask(2'h2);
        ctl.issue(SDR_CMD_RD, 2'h3, 12'h012, 16'h0000);
        ctl.set_mask(2'h0);
        ctl.nop(1);
        check("bank word", 16'h5A5A, dq_out);
        check("masked drive", 16'h0001, 16'(dq_oe));
        ctl.issue(SDR_CMD_RD, 2'h2, 12'h012, 16'h0000);
        ctl.nop(1);
        check("row word", mem[8'h12], dq_out);
    endtask
    // ==========
    // Sequence and watchdog
    initial
    begin
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        ctl.init(12'h023);
        ctl.issue(SDR_CMD_ACT, 2'h2, 12'hABC, 16'h0000);
        for (int i = 0; i < 8; i++)
            mem[8'h10 | 8'((5 + i) % 8)] = 16'hC000 + 16'(i);
        burst_wr(8'h15, 8, 16'hC000);
        rd_check(12'h021, 8'h13);
        rd_check(12'h03A, 8'h11);
        rd_check(12'h02B, 8'h16);
        rd_check(12'h033, 8'h13);
        rd_check(12'h030, 8'h17);
        single_write;
        full_page;
        refused;
        other_bank;
        give_verdict;
    end
    // Init wait alone is 2000 cycles; the rest stays well under 1000
    initial
    begin
        #300000;
        err_total++;
        give_verdict;
    end
endmodule
